// ---- pfs_frame_sequencer.sv ----
// pfs_frame_sequencer.sv: frame timing, contact scan, codec feed, link and display task
// assumes mux data, rxd, jumper and battery pins are asynchronous to core_clk_i
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_frame_sequencer
    import pfs_pkg::*;
#(
    parameter int T_FIRST    = `PFS_T_FIRST_US * `PFS_CLK_MHZ,
    parameter int T_SHORT    = `PFS_T_SHORT_US * `PFS_CLK_MHZ,
    parameter int T_LONG     = `PFS_T_LONG_US * `PFS_CLK_MHZ,
    parameter int BIT_CYC    = `PFS_CLK_HZ / `PFS_BAUD,
    parameter int CODEC_WAIT = `PFS_CODEC_WAIT_US * `PFS_CLK_MHZ,
    parameter int SMP_DEPTH  = `PFS_FRAME_SMP,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic [6:0]  mux_data_i,
    output logic      [3:0]  mux_addr_o,
    output logic             injection_en_o,
    output logic      [69:0] contact_frame_o,
    output logic             contact_valid_o,
    input  wire logic        smp_wr_en_i,
    input  wire logic [7:0]  smp_wr_addr_i,
    input  wire logic [15:0] smp_wr_data_i,
    output logic             codec_valid_o,
    input  wire logic        codec_ready_i,
    output logic      [15:0] codec_data_o,
    output logic             codec_cfg_start_o,
    input  wire logic        codec_cfg_done_i,
    output logic             atten_load_o,
    input  wire logic        rxd_i,
    output logic             txd_o,
    input  wire logic [1:0]  map_select_jumper_i,
    input  wire logic        battery_low_i,
    output logic             battery_low_o,
    output logic      [1:0]  mode_o,
    output logic             sync_probe_o,
    output logic             handler_activity_probe_o,
    output logic             background_activity_probe_o
);
    pfs_state_s_t q;
    pfs_state_s_t n;
    logic [15:0] smp_mem [2*SMP_DEPTH];
    logic        tick;
    logic [4:0]  nc;
    logic        poll;
    logic        push;
    logic        fifo_ready;
    logic        tx_go;
    logic [7:0]  tx_byte;
    logic [3:0]  grp;
    logic        bitv;

    assign push = (q.burst != '0) && fifo_ready;

    always_comb
    begin
        n = q;
        tx_go = 1'b0;
        tx_byte = '0;
        bitv = q.snap[q.idx];
        grp = 4'(q.cyc - 5'd1);
        n.m1 = mux_data_i;
        n.m2 = q.m1;
        n.rx1 = rxd_i;
        n.rx2 = q.rx1;
        n.b1 = battery_low_i;
        n.b2 = q.b1;
        n.j1 = map_select_jumper_i;
        n.j2 = q.j1;
        n.frame_v = 1'b0;
        n.cfg_start = 1'b0;
        n.atten = 1'b0;
        tick = q.run && (q.tmr == '0);
        nc = q.cyc + 5'd1;
        poll = tick && ((nc == 5'd1) || (nc >= 5'd10));
        n.sync = tick && (nc == 5'd1);
        if (q.run)
        begin
            // counter loads the period valid now; a reload written at this tick waits
            n.tmr = tick ? q.reload - 17'd1 : q.tmr - 17'd1;
        end
        // burst step first so a burst loaded at a tick is not overwritten
        if (push)
        begin
            n.burst = q.burst - 5'd1;
            n.rd = q.rd + 8'd1;
        end
        if (tick)
        begin
            n.cyc = nc;
            if (nc <= 5'd10)
            begin
                n.cap = `PFS_MUX_SETTLE;
            end
            if (nc == 5'd1)
            begin
                n.bank = ~q.bank;
                n.rd = '0;
                n.inj = 1'b1;
                n.mux = `PFS_ADDR_FIRST;
                n.reload = 17'(T_SHORT);
                n.burst = `PFS_BURST_FIRST;
            end
            else if (nc == 5'd9)
            begin
                n.reload = 17'(T_LONG);
            end
            else if (nc == `PFS_LAST_CYCLE)
            begin
                n.burst = `PFS_BURST_LAST;
                n.reload = 17'(T_FIRST);
                n.cyc = '0;
            end
            else if (nc >= 5'd10)
            begin
                n.burst = `PFS_BURST_MID;
            end
        end
        if (q.cap != '0)
        begin
            n.cap = q.cap - 4'd1;
            // address change waits for the capture so the mux has settled
            if (q.cap == 4'd1)
            begin
                n.contacts[7*grp +: 7] = q.m2;
                if (grp == 4'd4)
                begin
                    n.mux = `PFS_ADDR_SECOND;
                end
                else if (grp == 4'(`PFS_GROUPS - 1))
                begin
                    n.mux = `PFS_ADDR_IDLE;
                    n.inj = 1'b0;
                    n.frame_v = 1'b1;
                end
                else
                begin
                    n.mux = q.mux + 4'd1;
                end
            end
        end
        n.hprobe = tick || (n.burst != '0) || (n.cap != '0);

        case (q.st)
            PFS_CLEAR:
            begin
                n.clr = q.clr + 9'd1;
                if (q.clr == 9'(2*SMP_DEPTH - 1))
                begin
                    n.st = PFS_CWAIT;
                    n.wcnt = 25'(CODEC_WAIT);
                end
            end
            PFS_CWAIT:
            begin
                n.wcnt = q.wcnt - 25'd1;
                if (q.wcnt == '0)
                begin
                    n.st = PFS_PROG;
                    n.cfg_start = 1'b1;
                end
            end
            PFS_PROG:
            begin
                if (codec_cfg_done_i)
                begin
                    n.st = PFS_START;
                end
            end
            PFS_START:
            begin
                n.run = 1'b1;
                n.st = PFS_ATTEN;
            end
            PFS_ATTEN:
            begin
                n.atten = 1'b1;
                n.st = PFS_FIRST;
            end
            PFS_FIRST, PFS_BATT:
            begin
                if (q.st == PFS_BATT)
                begin
                    n.batt = q.b2;
                end
                if (q.chr_v)
                begin
                    n.chr_v = 1'b0;
                    n.st = PFS_ACK;
                    case (q.chr)
                        `PFS_CODE_DISP: begin n.mode = PFS_M_DISP; n.ack = `PFS_ACK_DISP; end
                        `PFS_CODE_CAL:  begin n.mode = PFS_M_CAL;  n.ack = `PFS_ACK_CAL;  end
                        `PFS_CODE_COD:  begin n.mode = PFS_M_COD;  n.ack = `PFS_ACK_COD;  end
                        default:        n.st = q.st;
                    endcase
                end
                else if ((q.st == PFS_BATT) && (q.mode == PFS_M_DISP))
                begin
                    // snapshot of whatever frame is current; frames in between are lost
                    n.snap = q.contacts;
                    n.idx = '0;
                    n.ph = '0;
                    n.st = PFS_DRAW;
                end
            end
            PFS_DRAW:
            begin
                if (q.chr_v)
                begin
                    n.st = PFS_BATT;
                end
                else if (!q.tx_busy)
                begin
                    tx_go = 1'b1;
                    case (q.ph)
                        2'd0: tx_byte = bitv ? `PFS_CMD_BIG : `PFS_CMD_SMALL;
                        2'd1: tx_byte = `PFS_HOR0 + 8'(q.idx % 7) * `PFS_PITCH
                                        + 8'(q.j2) * `PFS_MAP_SHIFT;
                        default: tx_byte = `PFS_VER0 + 8'(q.idx / 7) * `PFS_PITCH;
                    endcase
                    n.ph = (q.ph == 2'd2) ? 2'd0 : q.ph + 2'd1;
                    if (q.ph == 2'd2)
                    begin
                        n.idx = q.idx + 7'd1;
                        if (q.idx == 7'd69)
                        begin
                            n.st = PFS_BATT;
                        end
                    end
                end
            end
            PFS_ACK:
            begin
                if (!q.tx_busy)
                begin
                    tx_go = 1'b1;
                    tx_byte = q.ack;
                    n.st = PFS_BATT;
                end
            end
            default: n.st = PFS_CLEAR;
        endcase

        // poll after consume: a character arriving with the clear is kept
        if (poll && q.rx_full)
        begin
            n.chr = q.rx_byte;
            n.chr_v = 1'b1;
            n.rx_full = 1'b0;
        end

        if (!q.rx_busy)
        begin
            if (!q.rx2)
            begin
                n.rx_busy = 1'b1;
                n.rcnt = 14'(BIT_CYC / 2);
                n.rbit = '0;
            end
        end
        else if (q.rcnt != '0)
        begin
            n.rcnt = q.rcnt - 14'd1;
        end
        else
        begin
            n.rcnt = 14'(BIT_CYC - 1);
            n.rbit = q.rbit + 4'd1;
            if (q.rbit == 4'd0)
            begin
                n.rx_busy = !q.rx2;
            end
            else if (q.rbit <= 4'd8)
            begin
                n.rsh = {q.rx2, q.rsh[7:1]};
            end
            else
            begin
                n.rx_busy = 1'b0;
                if (q.rx2)
                begin
                    n.rx_byte = q.rsh;
                    n.rx_full = 1'b1;
                end
            end
        end

        if (tx_go)
        begin
            n.tx_busy = 1'b1;
            n.tsh = {1'b1, tx_byte, 1'b0};
            n.tbit = 4'd10;
            n.tcnt = 14'(BIT_CYC - 1);
        end
        else if (q.tx_busy)
        begin
            if (q.tcnt != '0)
            begin
                n.tcnt = q.tcnt - 14'd1;
            end
            else
            begin
                n.tcnt = 14'(BIT_CYC - 1);
                n.tsh = {1'b1, q.tsh[9:1]};
                n.tbit = q.tbit - 4'd1;
                n.tx_busy = (q.tbit != 4'd1);
            end
        end
        n.txd = n.tx_busy ? n.tsh[0] : 1'b1;
        n.bprobe = ((n.st == PFS_BATT) || (n.st == PFS_DRAW) || (n.st == PFS_ACK))
                   && !n.hprobe;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q <= '0;
            q.st <= PFS_CLEAR;
            q.reload <= 17'(T_FIRST);
            q.rx1 <= 1'b1;
            q.rx2 <= 1'b1;
            q.txd <= 1'b1;
        end
        else
        begin
            q <= n;
        end
    end

    // sample ping-pong: codec reads bank q.bank, the coder writes the other bank
    always_ff @(posedge core_clk_i)
    begin
        if (q.st == PFS_CLEAR)
        begin
            smp_mem[q.clr] <= '0;
        end
        else if (smp_wr_en_i && (smp_wr_addr_i < 8'(SMP_DEPTH)))
        begin
            smp_mem[q.bank ? 9'(smp_wr_addr_i) : 9'(SMP_DEPTH) + 9'(smp_wr_addr_i)] <= smp_wr_data_i;
        end
    end

    pfs_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (q.burst != '0),
        .in_ready_o  (fifo_ready),
        .in_data_i   (smp_mem[q.bank ? 9'(SMP_DEPTH) + 9'(q.rd) : 9'(q.rd)]),
        .out_valid_o (codec_valid_o),
        .out_ready_i (codec_ready_i),
        .out_data_o  (codec_data_o)
    );

    assign mux_addr_o = q.mux;
    assign injection_en_o = q.inj;
    assign contact_frame_o = q.contacts;
    assign contact_valid_o = q.frame_v;
    assign codec_cfg_start_o = q.cfg_start;
    assign atten_load_o = q.atten;
    assign txd_o = q.txd;
    assign battery_low_o = q.batt;
    assign mode_o = q.mode;
    assign sync_probe_o = q.sync;
    assign handler_activity_probe_o = q.hprobe;
    assign background_activity_probe_o = q.bprobe;

    frame_start_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        tick && (nc == 5'd1) |=> sync_probe_o && (q.burst == `PFS_BURST_FIRST) ##1 !sync_probe_o)
        else $error("frame start misses sync pulse or first burst");
    reload_defer_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        tick && (nc == 5'd9) |=> (q.tmr == 17'(T_SHORT - 1)) && (q.reload == 17'(T_LONG)))
        else $error("new period applied too early");
    frame_wrap_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        tick && (nc == `PFS_LAST_CYCLE) |=> (q.cyc == 5'd0) && (q.reload == 17'(T_FIRST))
        && (q.burst == `PFS_BURST_LAST))
        else $error("last cycle does not wrap");
    mux_jump_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (q.cap == 4'd1) && (grp == 4'd4) |=> (mux_addr_o == `PFS_ADDR_SECOND))
        else $error("address not moved to second mux");
    mux_idle_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (q.cap == 4'd1) && (grp == 4'd9) |=> (mux_addr_o == `PFS_ADDR_IDLE)
        && !injection_en_o && contact_valid_o)
        else $error("scan end not idle");
    burst_stall_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (q.burst != '0) && !fifo_ready && !tick |=> $stable(q.burst) && $stable(q.rd))
        else $error("burst advanced while fifo full");
    rx_poll_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        poll && q.rx_full |=> q.chr_v && (q.chr == $past(q.rx_byte)))
        else $error("polled character lost");
    draw_abort_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (q.st == PFS_DRAW) && q.chr_v |=> (q.st == PFS_BATT) ##1 (q.st == PFS_ACK))
        else $error("display mode not left on character");

endmodule // pfs_frame_sequencer

// ---- pfs_defines.svh ----
// pfs_defines.svh: offsets, codes and timing figures of the palate frame sequencer
// assumes a 100 MHz core clock; included by bare name from the sequencer and the top
//
// Functional notes
// - each frame is 28 cycles of differing length summing to 10 ms, repeating.
// - every tick increments a cycle counter from 0; its value selects the actions.
// - a period reloaded during a cycle only applies after the following tick.
// - per-cycle actions run at cycle start; the rest belongs to the background task.
// - cycle 1, 100 us: swap buffer, poll, injection on, address 1, 16 samples.
// - cycles 2 to 9, 50 us, capture; after cycle 5 the address jumps to 9.
// - cycle 9 loads a 500 us period at its tick, before capture and increment.
// - cycle 10, 500 us: 10 samples, last capture, address 0, injection off, poll.
// - cycles 11 to 27, 500 us each: 10 samples from previous frame, poll.
// - cycle 28: 4 samples, poll, load 100 us period, counter back to 0.
// - ten 7-bit contact groups are captured each frame into the contact buffer.
// - codec takes 200 samples per frame at 20 kHz; first burst of 16 fills it.
// - serial receiver is polled about every 500 us; a character enters the buffer.
// - serial link runs at 9600 baud, 8 data bits, no parity, one stop bit.
// - initialisation arms the tick timer and its event but keeps it stopped.
// - power-up: clear buffers, wait codec, program codec, start timer, attenuation.
// - after init wait for the first character, normally '3' for display mode.
// - each background pass checks the battery first, then runs the mode task.
// - display mode draws small or big circles for 70 bits using a jumper map.
// - rendering is not synchronised to frames; frames may be skipped.
// - any received character stops the drawing pass at once; an unknown one leaves display mode on.
// - three probes: frame sync, handler active, background active.
// - a mode code switches mode and an acknowledge byte is sent back.
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

`define PFS_CLK_MHZ      100
`define PFS_CLK_HZ       100000000
`define PFS_T_FIRST_US   100
`define PFS_T_SHORT_US   50
`define PFS_T_LONG_US    500
`define PFS_BAUD         9600
`define PFS_CODEC_WAIT_US 20000
`define PFS_MUX_SETTLE   4'h4
`define PFS_LAST_CYCLE   5'h1C
`define PFS_GROUPS       10
`define PFS_BURST_FIRST  5'h10
`define PFS_BURST_MID    5'h0A
`define PFS_BURST_LAST   5'h04
`define PFS_FRAME_SMP    200
`define PFS_ADDR_FIRST   4'h1
`define PFS_ADDR_SECOND  4'h9
`define PFS_ADDR_IDLE    4'h0
`define PFS_CODE_DISP    8'h33
`define PFS_CODE_CAL     8'h32
`define PFS_CODE_COD     8'h31
`define PFS_ACK_DISP     8'hA3
`define PFS_ACK_CAL      8'hA2
`define PFS_ACK_COD      8'hA1
`define PFS_CMD_SMALL    8'hC0
`define PFS_CMD_BIG      8'hC1
`define PFS_HOR0         8'h10
`define PFS_VER0         8'h10
`define PFS_PITCH        8'h0C
`define PFS_MAP_SHIFT    8'h04

`endif

// ---- pfs_pkg.sv ----
// pfs_pkg.sv: types of the palate frame sequencer
// assumes pfs_defines.svh for all figures
package pfs_pkg;

    typedef enum logic [3:0] {
        PFS_CLEAR = 4'h0,
        PFS_CWAIT = 4'h1,
        PFS_PROG  = 4'h3,
        PFS_START = 4'h2,
        PFS_ATTEN = 4'h6,
        PFS_FIRST = 4'h7,
        PFS_BATT  = 4'h5,
        PFS_DRAW  = 4'h4,
        PFS_ACK   = 4'hC
    } pfs_state_t;

    typedef enum logic [1:0] {
        PFS_M_DISP = 2'h0,
        PFS_M_CAL  = 2'h1,
        PFS_M_COD  = 2'h2
    } pfs_mode_t;

    typedef struct packed {
        pfs_state_t st;
        pfs_mode_t  mode;
        logic       run;
        logic [16:0] tmr;
        logic [16:0] reload;
        logic [4:0]  cyc;
        logic [4:0]  burst;
        logic [3:0]  cap;
        logic [7:0]  rd;
        logic        bank;
        logic [8:0]  clr;
        logic [24:0] wcnt;
        logic [3:0]  mux;
        logic        inj;
        logic [69:0] contacts;
        logic [69:0] snap;
        logic        frame_v;
        logic [6:0]  m1;
        logic [6:0]  m2;
        logic        rx1;
        logic        rx2;
        logic        b1;
        logic        b2;
        logic [1:0]  j1;
        logic [1:0]  j2;
        logic        batt;
        logic        rx_busy;
        logic [13:0] rcnt;
        logic [3:0]  rbit;
        logic [7:0]  rsh;
        logic [7:0]  rx_byte;
        logic        rx_full;
        logic [7:0]  chr;
        logic        chr_v;
        logic        tx_busy;
        logic [13:0] tcnt;
        logic [3:0]  tbit;
        logic [9:0]  tsh;
        logic        txd;
        logic [6:0]  idx;
        logic [1:0]  ph;
        logic [7:0]  ack;
        logic        sync;
        logic        hprobe;
        logic        bprobe;
        logic        cfg_start;
        logic        atten;
    } pfs_state_s_t;

endpackage

// ---- pfs_fifo.sv ----
// pfs_fifo.sv: sample FIFO between the sequencer and the codec port
// assumes one clock; both sides use valid/ready
`timescale 1ns/1ps
module pfs_fifo
    import pfs_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } pfs_fifo_s_t;

    pfs_fifo_s_t q;
    pfs_fifo_s_t d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o  = mem[q.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop)
        begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // storage left out of reset: contents are never read while empty
    always_ff @(posedge core_clk_i)
    begin
        if (push)
        begin
            mem[q.wp] <= in_data_i;
        end
    end

endmodule // pfs_fifo

// ---- pfs_partner.sv ----
// pfs_partner.sv: model of contact muxes, codec sample port and display-side serial link
// assumes one core clock; ready and rxd change at the falling edge, mux data follows the address at once
`timescale 1ns/1ps
module pfs_partner #(
    parameter int BIT_CYC = 16
) (
    input  wire logic       core_clk_i,
    input  wire logic [3:0] mux_addr_i,
    output logic      [6:0] mux_data_o,
    input  wire logic       codec_valid_i,
    output logic            codec_ready_o,
    input  wire logic       txd_i,
    output logic            rxd_o
);
    int         words = 0;
    int         n_tx  = 0;
    logic [7:0] last  = 8'h00;
    logic [7:0] b;
    // group value carries its own address so a wrong scan order shows
    assign mux_data_o = {3'h5, mux_addr_i};
    initial rxd_o = 1'b1;
    initial codec_ready_o = 1'b0;
    // half-rate taker so the fifo fills and stalls the burst
    always @(negedge core_clk_i) codec_ready_o <= !codec_ready_o;
    always @(posedge core_clk_i) if (codec_valid_i && codec_ready_o) words <= words + 1;
    always @(negedge core_clk_i)
    begin
        if (txd_i === 1'b0)
        begin
            repeat (BIT_CYC / 2) @(negedge core_clk_i);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYC) @(negedge core_clk_i);
                b[i] = txd_i;
            end
            repeat (BIT_CYC) @(negedge core_clk_i);
            last = b;
            n_tx++;
        end
    end
    task automatic send(input logic [7:0] c);
        for (int i = -1; i < 9; i++)
        begin
            @(negedge core_clk_i);
            rxd_o = (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : c[i];
            repeat (BIT_CYC - 1) @(negedge core_clk_i);
        end
    endtask
endmodule // pfs_partner

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench for the palate frame sequencer
// assumes shortened timing parameters; partner model answers on the far side
`timescale 1ns/1ps
`include "pfs_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top
    import pfs_pkg::*;
;
    localparam int FRAME = 20 + 8 * 10 + 19 * 40;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        inj, cv, vld, rdy, cst, cdn, atn, rxd, txd, bi, bo, sp, hp, bp;
    logic [3:0]  addr;
    logic [6:0]  mdat;
    logic [69:0] cfr;
    logic [69:0] exp_f;
    logic [1:0]  mode, jmp;
    logic        swe;
    logic [7:0]  swa;
    logic [15:0] swd, cdat;
    int          bad_count = 0;
    int          compares = 0;
    int          tmo = 0;
    always #5 clk = !clk;
    pfs_frame_sequencer #(.T_FIRST(20), .T_SHORT(10), .T_LONG(40), .BIT_CYC(16),
        .CODEC_WAIT(8)) uut (
        .core_clk_i(clk), .rstn_i(rstn), .mux_data_i(mdat), .mux_addr_o(addr),
        .injection_en_o(inj), .contact_frame_o(cfr), .contact_valid_o(cv),
        .smp_wr_en_i(swe), .smp_wr_addr_i(swa), .smp_wr_data_i(swd),
        .codec_valid_o(vld), .codec_ready_i(rdy), .codec_data_o(cdat),
        .codec_cfg_start_o(cst), .codec_cfg_done_i(cdn), .atten_load_o(atn),
        .rxd_i(rxd), .txd_o(txd), .map_select_jumper_i(jmp), .battery_low_i(bi),
        .battery_low_o(bo), .mode_o(mode), .sync_probe_o(sp),
        .handler_activity_probe_o(hp), .background_activity_probe_o(bp));
    pfs_partner pm (.core_clk_i(clk), .mux_addr_i(addr),
        .mux_data_o(mdat), .codec_valid_i(vld), .codec_ready_o(rdy), .txd_i(txd),
        .rxd_o(rxd));
    task results;
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard well above the few thousand cycles the run needs
    always @(posedge clk) if (++tmo == 20000) begin bad_count++; results; end
    task automatic init_chk;
        int n;
        for (n = 0; n < 1000 && cst !== 1'b1; n++) @(negedge clk);
        `CHK("cfg start", 1'b1, cst)
        repeat (20) @(negedge clk);
        `CHK("timer held", 1'b0, sp)
        cdn = 1'b1;
        for (n = 0; n < 200 && atn !== 1'b1; n++) @(negedge clk);
        `CHK("atten", 1'b1, atn)
    endtask
    task automatic mode_chk(input logic [7:0] c, input logic [7:0] a, input logic [1:0] m);
        int k;
        int n0;
        n0 = pm.n_tx;
        pm.send(c);
        for (k = 0; k < 3000 && !(pm.n_tx != n0 && pm.last === a); k++) @(negedge clk);
        `CHK("ack", a, pm.last)
        `CHK("mode", m, mode)
    endtask
    task automatic draw_chk;
        int k;
        int n0;
        n0 = pm.n_tx;
        for (k = 0; k < 400 && pm.n_tx == n0; k++) @(negedge clk);
        `CHK("draw", `PFS_CMD_BIG, pm.last)
        for (k = 0; k < 400 && pm.n_tx == n0 + 1; k++) @(negedge clk);
        `CHK("hor", `PFS_HOR0 + `PFS_MAP_SHIFT, pm.last)
    endtask
    task automatic frame_chk;
        int n;
        int v;
        logic bseen;
        for (n = 0; n < 2000 && sp !== 1'b1; n++) @(negedge clk);
        `CHK("addr first", `PFS_ADDR_FIRST, addr)
        `CHK("inj on", 1'b1, inj)
        `CHK("hprobe", 1'b1, hp)
        pm.words = 0;
        v = -9;
        n = 0;
        bseen = 1'b0;
        do
        begin
            @(negedge clk);
            n++;
            swe = (n == 5);
            bseen |= (bp === 1'b1);
            if (cv === 1'b1) v = n;
            if (n == v + 2)
            begin
                `CHK("addr idle", `PFS_ADDR_IDLE, addr)
                `CHK("inj off", 1'b0, inj)
            end
        end while (sp !== 1'b1 && n < 2000);
        for (int g = 0; g < 10; g++) exp_f[7*g+:7] = {3'h5, 4'(g < 5 ? g + 1 : g + 4)};
        `CHK("frame len", FRAME, n)
        `CHK("words", 200, pm.words)
        `CHK("contacts", exp_f, cfr)
        `CHK("bprobe", 1'b1, bseen)
        for (n = 0; n < 20 && vld !== 1'b1; n++) @(negedge clk);
        `CHK("sample", swd, cdat)
    endtask
    task automatic batt_chk;
        int n;
        bi = 1'b1;
        for (n = 0; n < 2000 && bo !== 1'b1; n++) @(negedge clk);
        `CHK("battery", 1'b1, bo)
    endtask
    initial
    begin
        cdn = 1'b0;
        bi = 1'b0;
        swe = 1'b0;
        swa = 8'h00;
        swd = 16'h1234;
        jmp = 2'h1;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        init_chk();
        mode_chk(`PFS_CODE_DISP, `PFS_ACK_DISP, PFS_M_DISP);
        draw_chk();
        frame_chk();
        mode_chk(`PFS_CODE_COD, `PFS_ACK_COD, PFS_M_COD);
        mode_chk(`PFS_CODE_CAL, `PFS_ACK_CAL, PFS_M_CAL);
        batt_chk();
        results();
    end
endmodule // tb_top
